// ==== src/seaa_pkg.sv ====
package seaa_pkg;

	// ********************************************************************
	// Array geometry and address masks.
	// ********************************************************************
	localparam int          ARR_DEPTH   = 8192;
	localparam int          ADDR_W      = 13;
	localparam int          DATA_W      = 8;
	localparam int          PAGE_W      = 5;
	localparam int          PAGE_BYTES  = 32;
	localparam int          FIFO_DEPTH  = 16;
	localparam logic [12:0] MASK_WIDE   = 13'h1fff;
	localparam logic [12:0] MASK_NARROW = 13'h0fff;
	localparam logic [12:0] QTR_WIDE    = 13'h1800;
	localparam logic [12:0] QTR_NARROW  = 13'h0c00;
	localparam logic [12:0] HALF_WIDE   = 13'h1000;
	localparam logic [12:0] HALF_NARROW = 13'h0800;
	localparam logic [7:0]  ERASED      = 8'hff;
	localparam logic [4:0]  PAGE_LAST   = 5'h1f;

	// ********************************************************************
	// Instruction codes, serial framing and protection codes.
	// ********************************************************************
	localparam logic [7:0]  OP_READ     = 8'h03;
	localparam logic [7:0]  OP_WRITE    = 8'h02;
	localparam logic [7:0]  OP_WRITE_ENABLE_INSTRUCTION     = 8'h06;
	localparam logic [2:0]  BIT_LAST    = 3'h7;
	localparam logic [2:0]  BIT_FIRST   = 3'h0;
	localparam logic [1:0]  BP_QTR      = 2'h1;
	localparam logic [1:0]  BP_HALF     = 2'h2;
	localparam logic [1:0]  BP_ALL      = 2'h3;

	// ********************************************************************
	// Pin slots and timing.
	// ********************************************************************
	localparam int          NPINS       = 3;
	localparam int          PIN_CS      = 0;
	localparam int          PIN_SCK     = 1;
	localparam int          PIN_SI      = 2;
	localparam logic [2:0]  PIN_RST     = 3'h1;
	localparam int          CLK_MHZ     = 40;
	localparam int          PROG_TIME_NS = 1000000;
	localparam int          TMR_W       = 26;

	typedef struct packed {
		logic [12:0] addr;
		logic [7:0]  data;
	} seaa_prog_t;

	typedef enum logic [5:0] {
		ST_IDLE  = 6'h01,
		ST_CMD   = 6'h02,
		ST_ADDR  = 6'h04,
		ST_READ  = 6'h08,
		ST_WDATA = 6'h10,
		ST_SKIP  = 6'h20
	} seaa_bus_st_t;

	typedef enum logic [2:0] {
		PG_IDLE = 3'h1,
		PG_PUSH = 3'h2,
		PG_WAIT = 3'h4
	} seaa_pg_st_t;

endpackage : seaa_pkg

// ==== src/seaa_fifo.sv ====
`timescale 1ns/1ps
module seaa_fifo #(
	parameter int WIDTH = 21,
	parameter int DEPTH = 16
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             ce,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW:0]      wr_q;
	logic [PW:0]      rd_q;

	assign in_ready  = !((wr_q[PW] != rd_q[PW]) && (wr_q[PW-1:0] == rd_q[PW-1:0]));
	assign out_valid = (wr_q != rd_q);
	assign out_data  = mem[rd_q[PW-1:0]];

	always_ff @(posedge clk) begin
		if (rst) begin
			wr_q <= '0;
			rd_q <= '0;
		end else if (ce) begin
			if (in_valid && in_ready)
				wr_q <= wr_q + 1'b1;
			if (out_valid && out_ready)
				rd_q <= rd_q + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (ce && in_valid && in_ready)
			mem[wr_q[PW-1:0]] <= in_data;
	end
endmodule : seaa_fifo

// ==== src/seaa_array.sv ====
`timescale 1ns/1ps
module seaa_array (
	input  wire logic                clk,
	input  wire logic                ce,
	input  wire logic                wr_en,
	input  wire seaa_pkg::seaa_prog_t wr,
	input  wire logic [12:0]         rd_addr,
	output logic      [7:0]          rd_data
);
	import seaa_pkg::*;

	logic [DATA_W-1:0] cells [ARR_DEPTH];

	// Delivered contents: every byte erased. Power-on reset never touches the cells.
	initial begin
		for (int i = 0; i < ARR_DEPTH; i++) begin
			cells[i] = ERASED;
		end
	end

	assign rd_data = cells[rd_addr];

	always_ff @(posedge clk) begin
		if (ce && wr_en)
			cells[wr.addr] <= wr.data;
	end
endmodule : seaa_array

// ==== src/seaa_top.sv ====
// Overview of operation
// - Read: take opcode and address, latch address, shift out addressed byte.
// - Held select during read advances the address and sends the next byte.
// - Read address wraps from the top location back to zero.
// - Raising select at any time ends the transfer cleanly.
// - Any byte location may start a read.
// - Read is ignored while a programming cycle runs.
// - Programming starts at select rise; flag clears when the time elapses.
// - Further data bytes are buffered and programmed in one cycle.
// - Write offset wraps inside the 32-byte page, overwriting buffered data.
// - Write refused unless the write enable latch is set.
// - Write refused while programming is in progress.
// - Select rise off a byte boundary discards the whole write.
// - Write refused when the page is block protected.
// - After reset a falling select edge is needed before decoding.
// - Reset clears write enable latch and programming flag.
// - Status protect bits are kept across reset untouched.
// - Delivered array reads as all ones; protect bits zero.
// - Unused upper address bits are ignored.
// - Wide variant uses a 13-bit array address.
// - Narrow variant uses a 12-bit array address.
// - Write enable instruction sets the write enable latch unless programming is in progress.
`timescale 1ns/1ps
module seaa_top #(
	parameter bit WIDE_ARRAY  = 1'b1,
	parameter int PROG_CYCLES = seaa_pkg::PROG_TIME_NS * seaa_pkg::CLK_MHZ / 1000
) (
	input  wire logic MCLK,
	input  wire logic SRST,
	input  wire logic CE,
	input  wire logic CS_N,
	input  wire logic SCK,
	input  wire logic SI,
	input  wire logic BLOCK_PROTECT_HI,
	input  wire logic BLOCK_PROTECT_LO,
	output logic      SO,
	output logic      SO_OE,
	output logic      WRITE_ENABLE_LATCH,
	output logic      WRITE_IN_PROGRESS
);
	import seaa_pkg::*;

	// ********************************************************************
	// Pin synchronisers and edge detection.
	// ********************************************************************
	logic [NPINS-1:0] pin_in;
	logic [NPINS-1:0] s1_q;
	logic [NPINS-1:0] s2_q;
	logic [NPINS-1:0] s3_q;

	assign pin_in = {SI, SCK, CS_N};

	for (genvar i = 0; i < NPINS; i++) begin : g_sync
		always_ff @(posedge MCLK) begin
			if (SRST) begin
				s1_q[i] <= PIN_RST[i];
				s2_q[i] <= PIN_RST[i];
				s3_q[i] <= PIN_RST[i];
			end else if (CE) begin
				s1_q[i] <= pin_in[i];
				s2_q[i] <= s1_q[i];
				s3_q[i] <= s2_q[i];
			end
		end
	end

	logic cs_n_s;
	logic cs_fall;
	logic cs_rise;
	logic sck_rise;
	logic sck_fall;

	assign cs_n_s   = s2_q[PIN_CS];
	assign cs_fall  = s3_q[PIN_CS] && !s2_q[PIN_CS];
	assign cs_rise  = !s3_q[PIN_CS] && s2_q[PIN_CS];
	assign sck_rise = !cs_n_s && s2_q[PIN_SCK] && !s3_q[PIN_SCK];
	assign sck_fall = !cs_n_s && !s2_q[PIN_SCK] && s3_q[PIN_SCK];

	// ********************************************************************
	// Serial shifter and decode.
	// ********************************************************************
	seaa_bus_st_t st_q;
	seaa_pg_st_t  pg_q;
	logic [2:0]   bit_q;
	logic [15:0]  sh_q;
	logic [15:0]  sh_next;
	logic         byte_end;
	logic         addr_hi_q;
	logic         is_wr_q;
	logic         wel_q;
	logic         wip_q;
	logic [12:0]  amask;
	logic [12:0]  addr_full;
	logic         prot;
	logic [1:0]   bp;

	assign sh_next   = {sh_q[14:0], s2_q[PIN_SI]};
	assign byte_end  = sck_rise && (bit_q == BIT_LAST);
	assign amask     = WIDE_ARRAY ? MASK_WIDE : MASK_NARROW;
	assign addr_full = sh_next[12:0] & amask;
	assign bp        = {BLOCK_PROTECT_HI, BLOCK_PROTECT_LO};

	always_comb begin
		case (bp)
			BP_QTR:  prot = addr_full >= (WIDE_ARRAY ? QTR_WIDE : QTR_NARROW);
			BP_HALF: prot = addr_full >= (WIDE_ARRAY ? HALF_WIDE : HALF_NARROW);
			BP_ALL:  prot = 1'b1;
			default: prot = 1'b0;
		endcase
	end

	always_ff @(posedge MCLK) begin
		if (SRST) begin
			bit_q <= BIT_FIRST;
			sh_q  <= '0;
		end else if (CE) begin
			if (cs_n_s)
				bit_q <= BIT_FIRST;
			else if (sck_rise)
				bit_q <= bit_q + 3'h1;
			if (sck_rise)
				sh_q <= sh_next;
		end
	end

	always_ff @(posedge MCLK) begin
		if (SRST) begin
			addr_hi_q <= 1'b0;
			is_wr_q   <= 1'b0;
		end else if (CE) begin
			if (cs_n_s)
				addr_hi_q <= 1'b0;
			else if (byte_end && st_q == ST_ADDR)
				addr_hi_q <= 1'b1;
			if (byte_end && st_q == ST_CMD)
				is_wr_q <= (sh_next[7:0] == OP_WRITE);
		end
	end

	// ********************************************************************
	// Transfer state machine.
	// ********************************************************************
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			st_q <= ST_IDLE;
		end else if (CE) begin
			if (cs_rise) begin
				st_q <= ST_IDLE;
			end else begin
				case (st_q)
					ST_IDLE: begin
						if (cs_fall)
							st_q <= ST_CMD;
					end
					ST_CMD: begin
						if (byte_end) begin
							if (sh_next[7:0] == OP_READ)
								st_q <= wip_q ? ST_SKIP : ST_ADDR;
							else if (sh_next[7:0] == OP_WRITE)
								st_q <= (wel_q && !wip_q) ? ST_ADDR : ST_SKIP;
							else
								st_q <= ST_SKIP;
						end
					end
					ST_ADDR: begin
						if (byte_end && addr_hi_q) begin
							if (!is_wr_q)
								st_q <= ST_READ;
							else
								st_q <= prot ? ST_SKIP : ST_WDATA;
						end
					end
					ST_READ:  st_q <= ST_READ;
					ST_WDATA: st_q <= ST_WDATA;
					ST_SKIP:  st_q <= ST_SKIP;
					default:  st_q <= ST_IDLE;
				endcase
			end
		end
	end

	// ********************************************************************
	// Read path.
	// ********************************************************************
	logic [12:0] rd_addr_q;
	logic [12:0] rd_sel;
	logic [7:0]  rd_data;
	logic [7:0]  tx_q;
	logic        rd_load;

	assign rd_sel  = (st_q == ST_ADDR) ? addr_full : rd_addr_q;
	assign rd_load = byte_end && ((st_q == ST_ADDR && addr_hi_q && !is_wr_q) || st_q == ST_READ);

	always_ff @(posedge MCLK) begin
		if (SRST) begin
			rd_addr_q <= '0;
			tx_q      <= '0;
		end else if (CE) begin
			if (rd_load) begin
				tx_q      <= rd_data;
				rd_addr_q <= (rd_sel + 13'h1) & amask;
			end else if (sck_fall && st_q == ST_READ) begin
				tx_q <= {tx_q[6:0], 1'b0};
			end
		end
	end

	always_ff @(posedge MCLK) begin
		if (SRST) begin
			SO    <= 1'b0;
			SO_OE <= 1'b0;
		end else if (CE) begin
			SO_OE <= !cs_n_s;
			if (cs_n_s)
				SO <= 1'b0;
			else if (sck_fall && st_q == ST_READ)
				SO <= tx_q[7];
		end
	end

	// ********************************************************************
	// Page buffer.
	// ********************************************************************
	logic [7:0]  pbuf [PAGE_BYTES];
	logic [31:0] pval_q;
	logic [7:0]  page_q;
	logic [4:0]  off_q;
	logic        got_q;
	logic        wr_step;
	logic        prog_go;

	assign wr_step = byte_end && st_q == ST_WDATA;
	assign prog_go = cs_rise && st_q == ST_WDATA && bit_q == BIT_FIRST && got_q;

	always_ff @(posedge MCLK) begin
		if (SRST) begin
			pval_q <= '0;
			page_q <= '0;
			off_q  <= '0;
			got_q  <= 1'b0;
		end else if (CE) begin
			if (byte_end && st_q == ST_ADDR && addr_hi_q && is_wr_q) begin
				page_q <= addr_full[12:PAGE_W];
				off_q  <= addr_full[PAGE_W-1:0];
				pval_q <= '0;
				got_q  <= 1'b0;
			end else if (wr_step) begin
				pval_q[off_q] <= 1'b1;
				off_q         <= off_q + 5'h1;
				got_q         <= 1'b1;
			end
		end
	end

	always_ff @(posedge MCLK) begin
		if (CE && wr_step)
			pbuf[off_q] <= sh_next[7:0];
	end

	// ********************************************************************
	// Programming engine, FIFO and array.
	// ********************************************************************
	logic [4:0]       idx_q;
	logic [TMR_W-1:0] tmr_q;
	logic             pace_q;
	logic             push_valid;
	logic             push_ready;
	logic             pop_valid;
	logic             pg_done;
	seaa_prog_t       push_ent;
	seaa_prog_t       pop_ent;

	assign push_valid = (pg_q == PG_PUSH) && pval_q[idx_q];
	assign push_ent   = '{addr: {page_q, idx_q}, data: pbuf[idx_q]};
	assign pg_done    = (pg_q == PG_WAIT) && (tmr_q == '0) && !pop_valid;

	always_ff @(posedge MCLK) begin
		if (SRST) begin
			pg_q  <= PG_IDLE;
			idx_q <= '0;
		end else if (CE) begin
			case (pg_q)
				PG_IDLE: begin
					idx_q <= '0;
					if (prog_go)
						pg_q <= PG_PUSH;
				end
				PG_PUSH: begin
					if (!pval_q[idx_q] || push_ready) begin
						idx_q <= idx_q + 5'h1;
						if (idx_q == PAGE_LAST)
							pg_q <= PG_WAIT;
					end
				end
				PG_WAIT: begin
					if (pg_done)
						pg_q <= PG_IDLE;
				end
				default: pg_q <= PG_IDLE;
			endcase
		end
	end

	always_ff @(posedge MCLK) begin
		if (SRST) begin
			tmr_q  <= '0;
			pace_q <= 1'b0;
		end else if (CE) begin
			pace_q <= !pace_q;
			if (prog_go)
				tmr_q <= TMR_W'(PROG_CYCLES - 1);
			else if (tmr_q != '0)
				tmr_q <= tmr_q - 1'b1;
		end
	end

	always_ff @(posedge MCLK) begin
		if (SRST) begin
			wip_q <= 1'b0;
			wel_q <= 1'b0;
		end else if (CE) begin
			if (prog_go)
				wip_q <= 1'b1;
			else if (pg_done)
				wip_q <= 1'b0;
			if (byte_end && st_q == ST_CMD && sh_next[7:0] == OP_WRITE_ENABLE_INSTRUCTION && !wip_q)
				wel_q <= 1'b1;
			else if (pg_done)
				wel_q <= 1'b0;
		end
	end

	assign WRITE_ENABLE_LATCH = wel_q;
	assign WRITE_IN_PROGRESS  = wip_q;

	seaa_fifo #(
		.WIDTH ($bits(seaa_prog_t)),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (MCLK),
		.rst       (SRST),
		.ce        (CE),
		.in_valid  (push_valid),
		.in_ready  (push_ready),
		.in_data   (push_ent),
		.out_valid (pop_valid),
		.out_ready (pace_q),
		.out_data  (pop_ent)
	);

	seaa_array u_array (
		.clk     (MCLK),
		.ce      (CE),
		.wr_en   (pop_valid && pace_q),
		.wr      (pop_ent),
		.rd_addr (rd_sel),
		.rd_data (rd_data)
	);

	// ********************************************************************
	// Assertions.
	// ********************************************************************
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (SRST || !CE);

	a_cs_abort: assert property (cs_rise |=> st_q == ST_IDLE)
		else $error("select rise did not end transfer");
	a_read_busy: assert property (st_q == ST_READ |-> !wip_q)
		else $error("read running during programming");
	a_prog_start: assert property (prog_go |=> wip_q && pg_q == PG_PUSH)
		else $error("programming did not start");
	a_wel_needed: assert property (prog_go |-> wel_q)
		else $error("write without enable latch");
	a_page_prot: assert property ($rose(st_q == ST_WDATA) |-> !$past(prot))
		else $error("protected page accepted");
	a_mid_byte: assert property (cs_rise && bit_q != BIT_FIRST && !wip_q |=> !wip_q)
		else $error("mid-byte write executed");
	a_read_wrap: assert property (rd_load && st_q == ST_READ && rd_addr_q == amask
		|=> rd_addr_q == '0)
		else $error("read address did not wrap");
	a_page_wrap: assert property (wr_step && off_q == PAGE_LAST |=> off_q == '0)
		else $error("page offset did not wrap");
	a_wel_clear: assert property ($fell(wip_q) |-> !wel_q)
		else $error("latch left set after programming");
	a_reset_flags: assert property ($past(SRST) |-> !wel_q && !wip_q)
		else $error("flags not cleared by reset");

	c_read_wrap: cover property (rd_load && rd_addr_q == '0 && st_q == ST_READ);
	c_page_write: cover property (prog_go && pval_q == '1);
	c_read_abort: cover property (cs_rise && st_q == ST_READ && bit_q != BIT_FIRST);
endmodule : seaa_top

// ==== test/seaa_master.sv ====
`timescale 1ns/1ps
module seaa_master (
	input  wire logic mclk,
	output logic      cs_n,
	output logic      sck,
	output logic      si,
	input  wire logic so
);

	// ****************************************************************
	// Serial bus master; pins change one step after a clock edge.
	// ****************************************************************
	initial begin
		cs_n = 1'b1;
		sck  = 1'b0;
		si   = 1'b0;
	end

	task tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : tick

	// The serial clock stays low outside frames.
	task start;
		tick(6);
		cs_n = 1'b0;
		tick(5);
	endtask : start

	// Output bits are taken just before the rise that follows their fall.
	task shift(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
		rx = 8'h00;
		for (int i = 7; i > 7 - nbits; i--) begin
			si = tx[i];
			tick(5);
			rx[i] = so;
			sck = 1'b1;
			tick(5);
			sck = 1'b0;
		end
	endtask : shift

	// A released data line shows the inverse of its last level.
	task stop;
		tick(5);
		cs_n = 1'b1;
		si   = ~si;
		tick(6);
	endtask : stop

endmodule : seaa_master

// ==== test/serial_eeprom_array_access_test.sv ====
`timescale 1ns/1ps
module serial_eeprom_array_access_test;
	import seaa_pkg::*;

	localparam int PROG = 2000;

	logic       mclk;
	logic       srst;
	logic       ce;
	logic       cs_n;
	logic       sck;
	logic       si;
	logic       so;
	logic       so_oe;
	logic       write_enable_latch;
	logic       write_in_progress;
	logic       bp_hi;
	logic       bp_lo;
	logic [7:0] mem [ARR_DEPTH];
	logic [7:0] r;
	int         num_errors;
	int         n_tests;
	int         cyc;
	int         t0;

	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	always @(posedge mclk) cyc <= cyc + 1;

	seaa_top #(.WIDE_ARRAY(1'b1), .PROG_CYCLES(PROG)) dut (
		.MCLK(mclk), .SRST(srst), .CE(ce), .CS_N(cs_n), .SCK(sck), .SI(si),
		.BLOCK_PROTECT_HI(bp_hi), .BLOCK_PROTECT_LO(bp_lo), .SO(so), .SO_OE(so_oe),
		.WRITE_ENABLE_LATCH(write_enable_latch), .WRITE_IN_PROGRESS(write_in_progress)
	);

	seaa_master bus (.mclk(mclk), .cs_n(cs_n), .sck(sck), .si(si), .so(so));

	// ****************************************************************
	// Comparison and closing.
	// ****************************************************************
	task test_done;
		$display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : test_done

	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task flags(input logic [1:0] exp);
		chk({6'h00, write_enable_latch, write_in_progress}, {6'h00, exp});
	endtask : flags

	task wait_wip(input logic lvl);
		int k;
		k = 0;
		while (write_in_progress !== lvl && k < 4 * PROG) begin
			bus.tick(1);
			k++;
		end
		if (k == 4 * PROG) begin
			chk(8'h00, 8'h01);
			test_done();
		end
	endtask : wait_wip

	// ****************************************************************
	// Frames.
	// ****************************************************************
	task write_enable_instruction;
		bus.start();
		bus.shift(OP_WRITE_ENABLE_INSTRUCTION, 8, r);
		bus.stop();
	endtask : write_enable_instruction

	task hdr(input logic [7:0] op, input logic [15:0] a);
		bus.start();
		bus.shift(op, 8, r);
		bus.shift(a[15:8], 8, r);
		bus.shift(a[7:0], 8, r);
	endtask : hdr

	// Accepted bytes land at the start offset plus their index, modulo the page.
	task wr(input logic [15:0] a, input int n, input int tail, input bit ok);
		logic [7:0]  d;
		logic [12:0] p;
		hdr(OP_WRITE, a);
		for (int i = 0; i < n; i++) begin
			d = 8'($urandom);
			p = {a[12:5], 5'(a[4:0] + i)};
			bus.shift(d, 8, r);
			if (ok) mem[p] = d;
		end
		if (tail > 0) bus.shift(8'($urandom), tail, r);
		bus.stop();
	endtask : wr

	task rd(input logic [15:0] a, input int n, input bit busy);
		logic [12:0] p;
		hdr(OP_READ, a);
		chk({7'h00, so_oe}, 8'h01);
		p = a[12:0];
		for (int i = 0; i < n; i++) begin
			bus.shift(8'($urandom), 8, r);
			chk(r, busy ? 8'h00 : mem[p]);
			p = p + 13'h0001;
		end
		bus.stop();
	endtask : rd

	// ****************************************************************
	// Main sequence.
	// ****************************************************************
	initial begin
		srst       = 1'b1;
		ce         = 1'b1;
		bp_hi      = 1'b0;
		bp_lo      = 1'b0;
		num_errors = 0;
		n_tests    = 0;
		cyc        = 0;
		void'($urandom(32'ha6ff));
		for (int i = 0; i < ARR_DEPTH; i++) mem[i] = 8'hff;
		bus.tick(5);
		srst = 1'b0;
		flags(2'b00);
		chk({7'h00, so_oe}, 8'h00);
		rd(16'($urandom), 3, 1'b0);
		wr(16'h0040, 1, 0, 1'b0);
		flags(2'b00);
		write_enable_instruction();
		flags(2'b10);
		wr(16'he05e, 34, 0, 1'b1);
		t0 = cyc;
		flags(2'b11);
		rd(16'h0040, 2, 1'b1);
		wr(16'h0100, 1, 0, 1'b0);
		wait_wip(1'b0);
		chk(8'(cyc - t0 >= PROG - 8), 8'h01);
		flags(2'b00);
		rd(16'h0040, 32, 1'b0);
		rd(16'h0100, 1, 1'b0);
		hdr(OP_READ, 16'h0003);
		bus.shift(8'h00, 4, r);
		bus.stop();
		write_enable_instruction();
		wr(16'h0200, 2, 3, 1'b0);
		flags(2'b10);
		rd(16'h0200, 2, 1'b0);
		for (int bp = 1; bp < 4; bp++) begin
			{bp_hi, bp_lo} = 2'(bp);
			wr(16'h1fe0, 1, 0, 1'b0);
			flags(2'b10);
		end
		{bp_hi, bp_lo} = 2'b00;
		wr(16'h1fff, 1, 0, 1'b1);
		flags(2'b11);
		// With the clock enable low the programming timer must not run down.
		ce = 1'b0;
		bus.tick(3 * PROG);
		flags(2'b11);
		ce = 1'b1;
		wait_wip(1'b0);
		rd(16'hfffe, 4, 1'b0);
		write_enable_instruction();
		srst = 1'b1;
		bus.tick(2);
		srst = 1'b0;
		flags(2'b00);
		rd(16'h005e, 4, 1'b0);
		test_done();
	end

endmodule : serial_eeprom_array_access_test
